// [logic/lwsc_pkg.sv]
package lwsc_pkg;

   // ------------------------------------------------------------
   // Waveform memory and playback
   // ------------------------------------------------------------
   localparam int WAVE_DEPTH = 512;
   localparam int WAVE_AW = 9;
   localparam int WAVE_DW = 8;
   localparam logic [8:0] LAST_ADDR = 9'h1FF;
   localparam logic [8:0] STOP_ADDR = 9'h1F9;
   localparam logic [8:0] SYNC_FALL_ADDR = 9'h0FD;
   localparam logic [8:0] SYNC_RISE_ADDR = 9'h1FC;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int ENTRY_PS = 200;
   localparam int ENTRY_RAW = (ENTRY_PS * CLK_MHZ) / 1000000;
   localparam int ENTRY_CYCLES = (ENTRY_RAW < 1) ? 1 : ENTRY_RAW;
   localparam int BLINK_HALF_MS = 250;
   localparam int BLINK_CYCLES = BLINK_HALF_MS * CLK_MHZ * 1000;
   localparam int CHECK_US = 1000;
   localparam int CHECK_CYCLES = CHECK_US * CLK_MHZ;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] LOAD_DATA_OFS = 8'h08;
   localparam logic [7:0] LOAD_CRC_OFS = 8'h0C;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
   localparam logic [7:0] IRQ_CLR_OFS = 8'h14;
   localparam logic [7:0] IRQ_EN_OFS = 8'h18;
   localparam logic [7:0] LOAD_CNT_OFS = 8'h1C;

   // CTRL bits
   localparam int CTRL_GATE_EN = 0;
   localparam int CTRL_LOAD = 1;
   localparam int CTRL_RESET = 2;
   localparam int CTRL_FORCE_ERR = 3;

   // Interrupt bits
   localparam int IRQ_W = 5;
   localparam int IRQ_LOAD_OK = 0;
   localparam int IRQ_CRC_FAIL = 1;
   localparam int IRQ_ERROR = 2;
   localparam int IRQ_WORKING = 3;
   localparam int IRQ_STOPPED = 4;

   // CRC
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h1021;

   // Reset values
   localparam logic CTRL_GATE_EN_RST = 1'b0;
   localparam logic [IRQ_W-1:0] IRQ_EN_RST = 5'h00;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {LWSC_STANDBY, LWSC_POWERUP, LWSC_WORKING, LWSC_ERROR} lwsc_state_t;

endpackage

// [logic/lwsc_top.sv]
`timescale 1ns/1ps
module lwsc_top
#(
   parameter int BLINK_CYCLES = lwsc_pkg::BLINK_CYCLES,
   parameter int CHECK_CYCLES = lwsc_pkg::CHECK_CYCLES
)
(
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [7:0] I_AWADDR,
   input wire logic I_WVALID,
   output logic O_WREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   output logic O_BVALID,
   input wire logic I_BREADY,
   output logic [1:0] O_BRESP,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   input wire logic [7:0] I_ARADDR,
   output logic O_RVALID,
   input wire logic I_RREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   input wire logic I_PLAYBACK_GATE_IN,
   input wire logic I_SUPPLY_VALID,
   input wire logic I_TEMP_OK,
   input wire logic I_BIST_DONE,
   input wire logic I_BIST_PASS,
   output logic [7:0] O_DAC_CODE,
   output logic O_SYNC,
   output logic O_LASER_ON,
   output logic O_SEED_EN,
   output logic O_SUPPLY_EN,
   output logic O_BIST_START,
   output logic O_REPORT_REQ,
   output logic O_STATE_LAMP_GREEN,
   output logic O_STATE_LAMP_RED,
   output logic O_IRQ
);

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [7:0] ar_addr;
   wire do_write = aw_held && w_held && !O_BVALID;
   wire wr_ctrl = do_write && (aw_addr == lwsc_pkg::CTRL_OFS) && w_strb[0];
   wire wr_data = do_write && (aw_addr == lwsc_pkg::LOAD_DATA_OFS) && w_strb[0];
   wire wr_crc = do_write && (aw_addr == lwsc_pkg::LOAD_CRC_OFS) && (w_strb[1:0] == 2'h3);
   wire wr_clr = do_write && (aw_addr == lwsc_pkg::IRQ_CLR_OFS) && w_strb[0];
   wire wr_en = do_write && (aw_addr == lwsc_pkg::IRQ_EN_OFS) && w_strb[0];
   wire wr_mapped = (aw_addr == lwsc_pkg::CTRL_OFS) || (aw_addr == lwsc_pkg::LOAD_DATA_OFS)
      || (aw_addr == lwsc_pkg::LOAD_CRC_OFS) || (aw_addr == lwsc_pkg::IRQ_CLR_OFS)
      || (aw_addr == lwsc_pkg::IRQ_EN_OFS);
   wire do_read = I_ARVALID && O_ARREADY;

   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         O_AWREADY <= 1'b0;
         O_WREADY <= 1'b0;
         O_BVALID <= 1'b0;
         O_BRESP <= lwsc_pkg::RESP_OKAY;
      end
      else
      begin
         O_AWREADY <= !aw_held && !(I_AWVALID && O_AWREADY) && !O_BVALID;
         O_WREADY <= !w_held && !(I_WVALID && O_WREADY) && !O_BVALID;
         if (I_AWVALID && O_AWREADY)
         begin
            aw_held <= 1'b1;
            aw_addr <= {I_AWADDR[7:2], 2'h0};
         end
         if (I_WVALID && O_WREADY)
         begin
            w_held <= 1'b1;
            w_data <= I_WDATA;
            w_strb <= I_WSTRB;
         end
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            O_BVALID <= 1'b1;
            O_BRESP <= wr_mapped ? lwsc_pkg::RESP_OKAY : lwsc_pkg::RESP_SLVERR;
         end
         else if (O_BVALID && I_BREADY)
            O_BVALID <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Supervisor
   // ------------------------------------------------------------
   lwsc_pkg::lwsc_state_t state;
   lwsc_pkg::lwsc_state_t next_state;
   logic [31:0] check_cnt;
   logic [31:0] blink_cnt;
   logic blink;
   logic gate_en;
   wire check_tick = (check_cnt == 32'(CHECK_CYCLES - 1));
   wire cmd_reset = wr_ctrl && w_data[lwsc_pkg::CTRL_RESET];
   wire cmd_error = wr_ctrl && w_data[lwsc_pkg::CTRL_FORCE_ERR];
   wire working = (state == lwsc_pkg::LWSC_WORKING);

   always_comb
   begin
      next_state = state;
      unique case (state)
         lwsc_pkg::LWSC_STANDBY:
            if (I_SUPPLY_VALID)
               next_state = lwsc_pkg::LWSC_POWERUP;
         lwsc_pkg::LWSC_POWERUP:
            if (I_BIST_DONE)
               next_state = I_BIST_PASS ? lwsc_pkg::LWSC_WORKING
                  : lwsc_pkg::LWSC_ERROR;
         lwsc_pkg::LWSC_WORKING:
            if (check_tick && (!I_SUPPLY_VALID || !I_TEMP_OK))
               next_state = lwsc_pkg::LWSC_ERROR;
         lwsc_pkg::LWSC_ERROR:
            next_state = lwsc_pkg::LWSC_ERROR;
      endcase
      if (cmd_error)
         next_state = lwsc_pkg::LWSC_ERROR;
      if (cmd_reset)
         next_state = lwsc_pkg::LWSC_STANDBY;
   end

   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         state <= lwsc_pkg::LWSC_STANDBY;
         check_cnt <= 32'h0000_0000;
         blink_cnt <= 32'h0000_0000;
         blink <= 1'b0;
         O_LASER_ON <= 1'b0;
         O_SEED_EN <= 1'b0;
         O_SUPPLY_EN <= 1'b0;
         O_BIST_START <= 1'b0;
         O_REPORT_REQ <= 1'b0;
         O_STATE_LAMP_GREEN <= 1'b0;
         O_STATE_LAMP_RED <= 1'b0;
      end
      else
      begin
         state <= next_state;
         check_cnt <= (!working || check_tick) ? 32'h0000_0000 : check_cnt + 32'h1;
         if (blink_cnt == 32'(BLINK_CYCLES - 1))
         begin
            blink_cnt <= 32'h0000_0000;
            blink <= !blink;
         end
         else
            blink_cnt <= blink_cnt + 32'h1;
         // Outputs are registered from next_state, so they change on the same edge as the state
         O_LASER_ON <= (next_state == lwsc_pkg::LWSC_WORKING);
         O_SEED_EN <= (next_state == lwsc_pkg::LWSC_WORKING);
         O_SUPPLY_EN <= (next_state == lwsc_pkg::LWSC_POWERUP)
            || (next_state == lwsc_pkg::LWSC_WORKING);
         O_BIST_START <= (next_state == lwsc_pkg::LWSC_POWERUP)
            && (state != lwsc_pkg::LWSC_POWERUP);
         O_REPORT_REQ <= (next_state == lwsc_pkg::LWSC_POWERUP)
            && (state != lwsc_pkg::LWSC_POWERUP);
         // Orange is both lamps together
         unique case (next_state)
            lwsc_pkg::LWSC_STANDBY:
            begin
               O_STATE_LAMP_GREEN <= 1'b1;
               O_STATE_LAMP_RED <= 1'b1;
            end
            lwsc_pkg::LWSC_POWERUP:
            begin
               O_STATE_LAMP_GREEN <= blink;
               O_STATE_LAMP_RED <= blink;
            end
            lwsc_pkg::LWSC_WORKING:
            begin
               O_STATE_LAMP_GREEN <= 1'b1;
               O_STATE_LAMP_RED <= 1'b0;
            end
            lwsc_pkg::LWSC_ERROR:
            begin
               O_STATE_LAMP_GREEN <= 1'b0;
               O_STATE_LAMP_RED <= 1'b1;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Waveform load
   // ------------------------------------------------------------
   logic [lwsc_pkg::WAVE_DW-1:0] wave_mem [2][lwsc_pkg::WAVE_DEPTH];
   logic active_bank;
   logic load_mode;
   logic crc_pending;
   logic crc_ok;
   logic [lwsc_pkg::WAVE_AW-1:0] load_cnt;
   logic [15:0] crc;
   logic [15:0] next_crc;
   wire data_take = wr_data && load_mode;
   wire load_last = data_take && (load_cnt == lwsc_pkg::LAST_ADDR);
   wire crc_take = wr_crc && crc_pending;
   wire crc_match = (w_data[15:0] == crc);

   always_comb
   begin
      next_crc = crc ^ {w_data[7:0], 8'h00};
      for (int i = 0; i < 8; i++)
         next_crc = next_crc[15] ? ((next_crc << 1) ^ lwsc_pkg::CRC_POLY) : (next_crc << 1);
   end

   // Loads go to the idle bank so a failed CRC leaves the old waveform playing
   always_ff @(posedge I_CLK)
   begin
      if (data_take)
         wave_mem[!active_bank][load_cnt] <= w_data[7:0];
   end

   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         active_bank <= 1'b0;
         load_mode <= 1'b0;
         crc_pending <= 1'b0;
         crc_ok <= 1'b0;
         load_cnt <= 9'h000;
         crc <= lwsc_pkg::CRC_INIT;
      end
      else
      begin
         if (wr_ctrl && w_data[lwsc_pkg::CTRL_LOAD])
         begin
            load_mode <= 1'b1;
            crc_pending <= 1'b0;
            load_cnt <= 9'h000;
            crc <= lwsc_pkg::CRC_INIT;
         end
         else if (data_take)
         begin
            crc <= next_crc;
            load_cnt <= load_cnt + 9'h001;
            if (load_last)
            begin
               load_mode <= 1'b0;
               crc_pending <= 1'b1;
            end
         end
         else if (crc_take)
         begin
            crc_pending <= 1'b0;
            crc_ok <= crc_match;
            if (crc_match)
               active_bank <= !active_bank;
         end
      end
   end

   // ------------------------------------------------------------
   // Playback
   // ------------------------------------------------------------
   logic [lwsc_pkg::WAVE_AW-1:0] rd_addr;
   logic [7:0] step_cnt;
   logic running;
   logic [7:0] mem_q;
   logic play_q;
   wire step = (step_cnt == 8'(lwsc_pkg::ENTRY_CYCLES - 1));
   wire play_ok = working && !load_mode;
   wire gate_hi = I_PLAYBACK_GATE_IN || !gate_en;
   wire stop_now = running && step && !gate_hi && (rd_addr == lwsc_pkg::STOP_ADDR);

   always_ff @(posedge I_CLK)
   begin
      mem_q <= wave_mem[active_bank][rd_addr];
   end

   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         rd_addr <= 9'h000;
         step_cnt <= 8'h00;
         running <= 1'b0;
         play_q <= 1'b0;
         O_DAC_CODE <= 8'h00;
         O_SYNC <= 1'b1;
      end
      else
      begin
         step_cnt <= step ? 8'h00 : step_cnt + 8'h01;
         play_q <= play_ok && running;
         if (!play_ok)
         begin
            rd_addr <= 9'h000;
            running <= 1'b0;
         end
         else if (!running)
         begin
            running <= gate_hi;
            rd_addr <= 9'h000;
         end
         else if (stop_now)
            running <= 1'b0;
         else if (step)
            rd_addr <= rd_addr + 9'h001;
         // Zero while loading or idle; a good CRC swaps banks at once, so old and new waveforms can mix mid-playback
         O_DAC_CODE <= play_q ? mem_q : 8'h00;
         if (play_ok && running && rd_addr == lwsc_pkg::SYNC_FALL_ADDR)
            O_SYNC <= 1'b0;
         else if (play_ok && running && rd_addr == lwsc_pkg::SYNC_RISE_ADDR)
            O_SYNC <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Interrupts, control and readback
   // ------------------------------------------------------------
   logic [lwsc_pkg::IRQ_W-1:0] irq_stat;
   logic [lwsc_pkg::IRQ_W-1:0] irq_en;
   logic [31:0] rd_mux;
   wire [lwsc_pkg::IRQ_W-1:0] irq_set = {stop_now,
      working == 1'b0 && next_state == lwsc_pkg::LWSC_WORKING,
      state != lwsc_pkg::LWSC_ERROR && next_state == lwsc_pkg::LWSC_ERROR,
      crc_take && !crc_match, crc_take && crc_match};
   wire [lwsc_pkg::IRQ_W-1:0] irq_clr = wr_clr ? w_data[lwsc_pkg::IRQ_W-1:0] : '0;
   wire [31:0] status_word = {24'h0, crc_ok, running, crc_pending, load_mode, 2'h0, state};

   always_comb
   begin
      unique case (ar_addr)
         lwsc_pkg::CTRL_OFS: rd_mux = {31'h0, gate_en};
         lwsc_pkg::STATUS_OFS: rd_mux = status_word;
         lwsc_pkg::IRQ_STAT_OFS: rd_mux = {27'h0, irq_stat};
         lwsc_pkg::IRQ_EN_OFS: rd_mux = {27'h0, irq_en};
         lwsc_pkg::LOAD_CNT_OFS: rd_mux = {23'h0, load_cnt};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   wire rd_mapped = (ar_addr == lwsc_pkg::CTRL_OFS) || (ar_addr == lwsc_pkg::STATUS_OFS)
      || (ar_addr == lwsc_pkg::IRQ_STAT_OFS) || (ar_addr == lwsc_pkg::IRQ_EN_OFS)
      || (ar_addr == lwsc_pkg::LOAD_CNT_OFS);
   logic ar_held;

   always_ff @(posedge I_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         gate_en <= lwsc_pkg::CTRL_GATE_EN_RST;
         irq_stat <= '0;
         irq_en <= lwsc_pkg::IRQ_EN_RST;
         O_IRQ <= 1'b0;
         ar_held <= 1'b0;
         ar_addr <= 8'h00;
         O_ARREADY <= 1'b0;
         O_RVALID <= 1'b0;
         O_RDATA <= 32'h0000_0000;
         O_RRESP <= lwsc_pkg::RESP_OKAY;
      end
      else
      begin
         if (wr_ctrl)
            gate_en <= w_data[lwsc_pkg::CTRL_GATE_EN];
         if (wr_en)
            irq_en <= w_data[lwsc_pkg::IRQ_W-1:0];
         // Set wins over a clear in the same cycle
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
         O_IRQ <= |(((irq_stat & ~irq_clr) | irq_set) & (wr_en ? w_data[4:0] : irq_en));
         O_ARREADY <= !ar_held && !do_read && !O_RVALID;
         if (do_read)
         begin
            ar_held <= 1'b1;
            ar_addr <= {I_ARADDR[7:2], 2'h0};
         end
         if (ar_held)
         begin
            ar_held <= 1'b0;
            O_RVALID <= 1'b1;
            O_RDATA <= rd_mux;
            O_RRESP <= rd_mapped ? lwsc_pkg::RESP_OKAY : lwsc_pkg::RESP_SLVERR;
         end
         else if (O_RVALID && I_RREADY)
            O_RVALID <= 1'b0;
      end
   end

endmodule

// [verif/lwsc_asserts.sv]
`timescale 1ns/1ps
module lwsc_asserts
(
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic I_AWVALID,
   input wire logic O_AWREADY,
   input wire logic I_WVALID,
   input wire logic O_WREADY,
   input wire logic O_BVALID,
   input wire logic I_ARVALID,
   input wire logic O_ARREADY,
   input wire logic O_RVALID,
   input wire logic [7:0] O_DAC_CODE,
   input wire logic O_LASER_ON,
   input wire logic O_SEED_EN,
   input wire logic O_SUPPLY_EN,
   input wire logic O_BIST_START,
   input wire logic O_REPORT_REQ,
   input wire logic O_STATE_LAMP_GREEN,
   input wire logic O_STATE_LAMP_RED
);
   // ----
   // Output relations
   // ----
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_B);
   wire red_only = O_STATE_LAMP_RED && !O_STATE_LAMP_GREEN;
   wire green_only = O_STATE_LAMP_GREEN && !O_STATE_LAMP_RED;
   a_seed_laser: assert property (O_SEED_EN == O_LASER_ON)
      else $error("seed enable and laser on differ");
   a_green_laser: assert property (O_LASER_ON == green_only)
      else $error("green lamp and laser on differ");
   a_error_dark: assert property (red_only |-> !O_SUPPLY_EN && !O_LASER_ON)
      else $error("supplies or laser on in error");
   // Only a register write may end the error state
   a_error_exit: assert property ($fell(red_only) |-> O_BVALID || $past(O_BVALID))
      else $error("error left without a command");
   a_dark_dac: assert property (!O_LASER_ON [*3] |-> O_DAC_CODE == 8'h00)
      else $error("converter code while laser off");
   a_start_pulse: assert property ($rose(O_BIST_START) |=> !O_BIST_START)
      else $error("self test start not a pulse");
   a_report_pair: assert property (O_BIST_START == O_REPORT_REQ)
      else $error("report and self test start differ");
   a_powerup_on: assert property ($rose(O_BIST_START) |-> ##[0:2] O_SUPPLY_EN)
      else $error("supplies off in powerup");
   a_b_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
      |-> ##[1:3] O_BVALID)
      else $error("write response late");
   a_r_answer: assert property (I_ARVALID && O_ARREADY |-> ##2 O_RVALID)
      else $error("read response late");
endmodule
bind lwsc_top lwsc_asserts i_lwsc_asserts (.*);

// [verif/lwsc_host.sv]
`timescale 1ns/1ps
module lwsc_host
(
   input wire logic i_clk,
   output logic o_awvalid,
   input wire logic i_awready,
   output logic [7:0] o_awaddr,
   output logic o_wvalid,
   input wire logic i_wready,
   output logic [31:0] o_wdata,
   input wire logic i_bvalid,
   output logic o_bready,
   input wire logic [1:0] i_bresp,
   output logic o_arvalid,
   input wire logic i_arready,
   output logic [7:0] o_araddr,
   input wire logic i_rvalid,
   output logic o_rready,
   input wire logic [31:0] i_rdata,
   input wire logic [1:0] i_rresp
);
   // ----
   // Bus master
   // ----
   logic s_aw, s_w, s_b, s_ar, s_r;
   logic [1:0] s_bresp, s_rresp;
   logic [31:0] s_rdata;
   initial {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready, o_awaddr, o_wdata, o_araddr} = '0;
   // Handshakes latched at the edge, read 1 ns later
   always @(posedge i_clk)
   begin
      {s_aw, s_w, s_b} <= {o_awvalid && i_awready, o_wvalid && i_wready, i_bvalid && o_bready};
      {s_ar, s_r} <= {o_arvalid && i_arready, i_rvalid && o_rready};
      {s_bresp, s_rresp, s_rdata} <= {i_bresp, i_rresp, i_rdata};
   end
   // Released lines show the inverse, never the stale value
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge i_clk);
      #1;
      {o_awvalid, o_awaddr, o_wvalid, o_wdata, o_bready} <= {1'b1, a, 1'b1, d, 1'b1};
      do
      begin
         @(posedge i_clk);
         #1;
         if (s_aw) {o_awvalid, o_awaddr} <= {1'b0, ~a};
         if (s_w) {o_wvalid, o_wdata} <= {1'b0, ~d};
      end
      while (!s_b);
      o_bready <= 1'b0;
      r = s_bresp;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge i_clk);
      #1;
      {o_arvalid, o_araddr, o_rready} <= {1'b1, a, 1'b1};
      do
      begin
         @(posedge i_clk);
         #1;
         if (s_ar) {o_arvalid, o_araddr} <= {1'b0, ~a};
      end
      while (!s_r);
      o_rready <= 1'b0;
      {d, r} = {s_rdata, s_rresp};
   endtask
endmodule

// [verif/laser_waveform_state_controller_bench.sv]
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin failures++; \
   $display("BAD %s exp %0h got %0h", n, e, s); end end
module laser_waveform_state_controller_bench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic gate = 1'b1;
   logic temp_ok = 1'b1;
   logic [2:0] bist = 3'b000;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic sync, laser, seed, sup_en, start, report, green, red, irq;
   logic [7:0] awaddr, araddr, dac;
   logic [31:0] wdata, rdata, d;
   logic [1:0] bresp, rresp, r;
   int failures = 0;
   int comparisons = 0;
   int n;
   always #4 clk = ~clk;
   // Short blink and check periods keep the run brief
   lwsc_top #(.BLINK_CYCLES(4), .CHECK_CYCLES(8)) i_lwsc_top
   (
      .I_CLK(clk), .I_RST_B(rst_b), .I_AWVALID(awvalid), .O_AWREADY(awready),
      .I_AWADDR(awaddr), .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata),
      .I_WSTRB(4'hF), .O_BVALID(bvalid), .I_BREADY(bready), .O_BRESP(bresp),
      .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr), .O_RVALID(rvalid),
      .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp), .I_PLAYBACK_GATE_IN(gate),
      .I_SUPPLY_VALID(bist[2]), .I_TEMP_OK(temp_ok), .I_BIST_DONE(bist[1]),
      .I_BIST_PASS(bist[0]), .O_DAC_CODE(dac), .O_SYNC(sync), .O_LASER_ON(laser),
      .O_SEED_EN(seed), .O_SUPPLY_EN(sup_en), .O_BIST_START(start), .O_REPORT_REQ(report),
      .O_STATE_LAMP_GREEN(green), .O_STATE_LAMP_RED(red), .O_IRQ(irq)
   );
   lwsc_host i_lwsc_host
   (
      .i_clk(clk), .o_awvalid(awvalid), .i_awready(awready), .o_awaddr(awaddr),
      .o_wvalid(wvalid), .i_wready(wready), .o_wdata(wdata), .i_bvalid(bvalid),
      .o_bready(bready), .i_bresp(bresp), .o_arvalid(arvalid), .i_arready(arready),
      .o_araddr(araddr), .i_rvalid(rvalid), .o_rready(rready), .i_rdata(rdata), .i_rresp(rresp)
   );
   // ----
   // Helpers
   // ----
   task automatic w(input logic [7:0] a, input logic [31:0] v);
      i_lwsc_host.wr(a, v, r);
   endtask
   task automatic reg_is(input string nm, input logic [7:0] a, input logic [31:0] m, e);
      i_lwsc_host.rd(a, d, r);
      `CHK(nm, e, d & m)
   endtask
   task automatic irq_is(input logic e);
      repeat (2) @(negedge clk);
      `CHK("irq", e, irq)
   endtask
   task automatic state_is(input logic [31:0] e);
      reg_is("state", lwsc_pkg::STATUS_OFS, 32'h3, e);
   endtask
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      c = c ^ {b, 8'h00};
      for (int k = 0; k < 8; k++)
         c = c[15] ? ({c[14:0], 1'b0} ^ lwsc_pkg::CRC_POLY) : {c[14:0], 1'b0};
      return c;
   endfunction
   // ----
   // Scenarios
   // ----
   task automatic t_bus;
      `CHK("reset lamps", 4'b0011, {laser, seed, green, red})
      state_is(32'h0);
      i_lwsc_host.wr(8'h40, 32'h1, r);
      `CHK("bresp", lwsc_pkg::RESP_SLVERR, r)
      reg_is("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
      `CHK("rresp", lwsc_pkg::RESP_SLVERR, r)
      reg_is("irq en", lwsc_pkg::IRQ_EN_OFS, 32'h1F, 32'(lwsc_pkg::IRQ_EN_RST));
      w(lwsc_pkg::IRQ_EN_OFS, 32'h1F);
      reg_is("irq en", lwsc_pkg::IRQ_EN_OFS, 32'h1F, 32'h1F);
   endtask
   task automatic t_fail;
      int on;
      on = 0;
      @(posedge clk) bist <= 3'b100;
      for (n = 0; n < 50 && start !== 1'b1; n++) @(negedge clk);
      `CHK("report", 1'b1, report)
      state_is(32'h1);
      for (n = 0; n < 16; n++)
         @(negedge clk) on += int'(green === 1'b1);
      `CHK("blink", 1'b1, on > 0 && on < 16)
      @(posedge clk) bist <= 3'b110;
      for (n = 0; n < 50 && {green, red, sup_en} !== 3'b010; n++) @(negedge clk);
      `CHK("bist fail", 3'b010, {green, red, sup_en})
      irq_is(1'b1);
      w(lwsc_pkg::IRQ_EN_OFS, 32'h0);
      irq_is(1'b0);
      w(lwsc_pkg::IRQ_EN_OFS, 32'h1F);
      reg_is("irq stat", lwsc_pkg::IRQ_STAT_OFS, 32'h1F, 32'h4);
      w(lwsc_pkg::IRQ_CLR_OFS, 32'h1F);
      irq_is(1'b0);
      @(posedge clk) bist <= 3'b000;
      repeat (20) @(negedge clk);
      state_is(32'h3);
      w(lwsc_pkg::CTRL_OFS, 32'h1 << lwsc_pkg::CTRL_RESET);
      state_is(32'h0);
      @(posedge clk) bist <= 3'b111;
      for (n = 0; n < 50 && laser !== 1'b1; n++) @(negedge clk);
      `CHK("working", 4'b1110, {laser, seed, green, red})
      state_is(32'h2);
   endtask
   task automatic t_load(input logic [15:0] bad, input int ev);
      logic [15:0] c;
      c = lwsc_pkg::CRC_INIT;
      w(lwsc_pkg::CTRL_OFS, 32'h1 << lwsc_pkg::CTRL_LOAD);
      for (int i = 0; i < 512; i++)
      begin
         w(lwsc_pkg::LOAD_DATA_OFS, 32'(i[7:0]));
         c = crc_step(c, i[7:0]);
      end
      reg_is("load mode", lwsc_pkg::STATUS_OFS, 32'h10, 32'h0);
      w(lwsc_pkg::LOAD_CRC_OFS, {16'h0, c ^ bad});
      reg_is("crc", lwsc_pkg::IRQ_STAT_OFS, 32'h3, 32'h1 << ev);
      w(lwsc_pkg::IRQ_CLR_OFS, 32'h1F);
   endtask
   task automatic t_play;
      logic [7:0] p;
      logic q;
      int s;
      repeat (8) @(negedge clk);
      {p, q, s} = {dac, sync, 32'h0};
      for (n = 1; n <= 1100; n++)
      begin
         @(negedge clk);
         `CHK("dac step", p + 8'h1, dac)
         if (sync && !q && s != 0) `CHK("sync period", lwsc_pkg::WAVE_DEPTH, n - s)
         if (sync && !q) s = n;
         {p, q} = {dac, sync};
      end
      // Gate low stops at entry 505, whose code is F9
      w(lwsc_pkg::CTRL_OFS, 32'h1);
      @(posedge clk) gate <= 1'b0;
      p = 8'h00;
      for (n = 0; n < 1200; n++)
         @(negedge clk) if (dac !== 8'h00) p = dac;
      `CHK("last code", 8'hF9, p)
      reg_is("stopped", lwsc_pkg::IRQ_STAT_OFS, 32'h10, 32'h10);
      @(posedge clk) gate <= 1'b1;
      for (n = 0; n < 20 && dac !== 8'h01; n++) @(negedge clk);
      `CHK("restart", 8'h01, dac)
      @(posedge clk) temp_ok <= 1'b0;
      for (n = 0; n < 100 && {laser, green, red, sup_en} !== 4'b0010; n++) @(negedge clk);
      `CHK("overheat", 4'b0010, {laser, green, red, sup_en})
      @(posedge clk) temp_ok <= 1'b1;
      repeat (40) @(negedge clk);
      state_is(32'h3);
   endtask
   task automatic conclude;
      if (failures == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(negedge clk);
      t_bus;
      t_fail;
      t_load(16'h1234, lwsc_pkg::IRQ_CRC_FAIL);
      t_load(16'h0000, lwsc_pkg::IRQ_LOAD_OK);
      t_play;
      conclude;
   end
   initial
   begin
      #400000;
      failures++;
      conclude;
   end
endmodule
